/* File: core/dmam_top.sv */
// Data memory address modifier: bank, index and row pointer registers and real address forming.
`timescale 1ns/10ps

// Operation
// - Bank register: four bits, only bit zero stored
// - Reset clears every bank register bit
// - Bank value selects first or second page
// - System registers mapped alike in every bank
// - Interrupt entry clears bank after it is saved
// - Index spans 7AH-7CH, seven effective bits
// - Index enable is status word bit zero
// - Index enable ORs index into operand address
// - Index high nibble fixed zero, bank unmodified
// - Row pointer shares 7AH/7BH, three row bits used
// - Pointer enable is 7AH most significant bit
// - Pointer gives indirect bank/row, register gives column
// - Pointer bank bits fixed zero, bank zero
// - Reset clears pointer, index and status nibbles
// - Only listed instructions get address modification
// - Both enables clear: addresses used as encoded
// - Indirect store without pointer: operand bank/row
// - Indirect load: register column source, operand destination
// - Pointer substitutes only in indirect transfers
// - File store copies window into file location
// - File fetch copies file location into window
// - Index modifies indirect row too, unless the pointer is enabled
module dmam_top (
   // Clock and reset
   input  wire logic                    sys_clk_i,
   input  wire logic                    rst_i,
   // System register access from the CPU
   input  wire dmam_pkg::dmam_sreg_req_t sreg_req_i,
   input  wire logic [6:0]              sreg_raddr_i,
   output logic [3:0]                   sreg_rdata_o,
   output logic                         sreg_rhit_o,
   // Interrupt entry, after the status has been saved
   input  wire logic                    int_saved_i,
   // Decoded instruction
   input  wire dmam_pkg::dmam_op_t      op_i,
   input  wire logic [2:0]              opnd_row_i,
   input  wire logic [3:0]              opnd_col_i,
   input  wire logic [3:0]              greg_data_i,
   input  wire logic [6:0]              file_loc_i,
   // Register file read data for a fetch
   input  wire logic [3:0]              file_rdata_i,
   // Real addresses towards the data memory
   output logic                         addr_vld_o,
   output dmam_pkg::dmam_addr_t         opnd_addr_o,
   output logic                         ind_vld_o,
   output dmam_pkg::dmam_addr_t         src_addr_o,
   output dmam_pkg::dmam_addr_t         dst_addr_o,
   // Register file store
   output dmam_pkg::dmam_file_req_t     file_req_o,
   // Current state for the decoder and the interrupt stack
   output logic [3:0]                   window_o,
   output logic [3:0]                   status_o,
   output logic                         ofs_en_o,
   output logic                         ptr_en_o
);
   import dmam_pkg::*;

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // True for every instruction whose operand address may be modified.
   function automatic logic is_modifiable(input dmam_op_t op);
      begin
         case (op)
            DMAM_OP_ARITH,
            DMAM_OP_LOGIC,
            DMAM_OP_SKIP_BITS,
            DMAM_OP_SKIP_CMP,
            DMAM_OP_LOAD,
            DMAM_OP_STORE,
            DMAM_OP_MOVE_IMM,
            DMAM_OP_IND_STORE,
            DMAM_OP_IND_LOAD: is_modifiable = 1'b1;
            default:          is_modifiable = 1'b0;
         endcase
      end
   endfunction : is_modifiable

   // Read view of one system register nibble, with fixed bits as zero.
   function automatic logic [4:0] sreg_view(input logic [6:0] addr, input dmam_state_t s);
      begin
         case (addr)
            DMAM_WINDOW_ADDR:   sreg_view = {1'b1, s.window};
            DMAM_PAGE_ADDR:     sreg_view = {1'b1, 3'b000, s.page};
            DMAM_OFS_HIGH_ADDR: sreg_view = {1'b1, s.ptr_en, 3'b000};
            DMAM_OFS_MID_ADDR:  sreg_view = {1'b1, 1'b0, s.mid};
            DMAM_OFS_LOW_ADDR:  sreg_view = {1'b1, s.low};
            DMAM_STATUS_ADDR:   sreg_view = {1'b1, s.status};
            default:            sreg_view = {1'b0, DMAM_ZERO_NIB};
         endcase
      end
   endfunction : sreg_view

   // ****************************************************************
   // State
   // ****************************************************************
   dmam_state_t s_q;
   dmam_state_t s_d;

   // Effective index and pointer fields derived from stored bits.
   logic       ofs_en;
   logic       ptr_en;
   logic [3:0] ix_bank;
   logic [2:0] ix_row;
   logic [3:0] ix_col;
   logic [3:0] mp_bank;
   logic [2:0] mp_row;
   logic [3:0] page_bank;
   dmam_addr_t direct;
   dmam_addr_t indirect;
   logic [4:0] rview;

   // ****************************************************************
   // Address forming
   // ****************************************************************

   // The index is eleven bits: the high four ride on the bank, the rest on row and column.
   // Both the high nibble and bit three of the middle nibble are held at zero in this
   // variant, so the bank can never be moved by the index.
   always_comb begin
      ofs_en    = s_q.status[DMAM_OFS_EN_BIT];
      ptr_en    = s_q.ptr_en;
      ix_bank   = DMAM_ZERO_NIB;
      ix_row    = s_q.mid;
      ix_col    = s_q.low;
      mp_bank   = DMAM_ZERO_NIB;
      mp_row    = s_q.mid;
      page_bank = {3'b000, s_q.page};
   end

   // Direct operand address, index modified only for listed instructions with the flag set.
   always_comb begin
      direct.bank = page_bank;
      direct.row  = opnd_row_i;
      direct.col  = opnd_col_i;
      if (ofs_en && is_modifiable(op_i)) begin
         direct.bank = page_bank | ix_bank;
         direct.row  = opnd_row_i | ix_row;
         direct.col  = opnd_col_i | ix_col;
      end
   end

   // Indirect address: bank and row follow the (possibly index modified) operand unless
   // the pointer is enabled; the column always comes from the general register.
   always_comb begin
      indirect.bank = direct.bank;
      indirect.row  = direct.row;
      indirect.col  = greg_data_i;
      if (ptr_en) begin
         indirect.bank = mp_bank;
         indirect.row  = mp_row;
      end
   end

   // Combinational read view of the addressed system register, registered in the next state.
   always_comb begin
      rview = sreg_view(sreg_raddr_i, s_q);
   end

   // ****************************************************************
   // Next state
   // ****************************************************************

   // A single process owns every state bit so that priorities are visible in one place.
   always_comb begin
      s_d = s_q;

      // System register writes ignore the bank: the seven-bit location alone decides.
      if (sreg_req_i.wr) begin
         case (sreg_req_i.addr)
            DMAM_WINDOW_ADDR: begin
               s_d.window = sreg_req_i.wdata;
            end
            DMAM_PAGE_ADDR: begin
               s_d.page = sreg_req_i.wdata[0];
            end
            DMAM_OFS_HIGH_ADDR: begin
               s_d.ptr_en = sreg_req_i.wdata[DMAM_PTR_EN_BIT];
            end
            DMAM_OFS_MID_ADDR: begin
               s_d.mid = sreg_req_i.wdata[2:0];
            end
            DMAM_OFS_LOW_ADDR: begin
               s_d.low = sreg_req_i.wdata;
            end
            DMAM_STATUS_ADDR: begin
               s_d.status = sreg_req_i.wdata;
            end
            default: begin
               s_d.rhit = s_q.rhit;
            end
         endcase
      end

      // Interrupt entry returns to the first page; it wins over a write in the same
      // cycle because the handler must always start there.
      if (int_saved_i) begin
         s_d.page = 1'b0;
      end

      // Window register and register file transfers.
      s_d.file.we    = 1'b0;
      s_d.file.addr  = file_loc_i;
      s_d.file.wdata = s_q.window;
      case (op_i)
         DMAM_OP_FILE_STORE: begin
            s_d.file.we = 1'b1;
         end
         DMAM_OP_FILE_FETCH: begin
            s_d.window = file_rdata_i;
         end
         default: begin
            s_d.file.we = 1'b0;
         end
      endcase

      // Addresses are presented one cycle after the decoder names the instruction.
      s_d.avld  = is_modifiable(op_i);
      s_d.ivld  = (op_i == DMAM_OP_IND_STORE) || (op_i == DMAM_OP_IND_LOAD);
      s_d.opnd  = direct;
      s_d.src   = direct;
      s_d.dst   = direct;
      case (op_i)
         DMAM_OP_IND_STORE: begin
            s_d.src = direct;
            s_d.dst = indirect;
         end
         DMAM_OP_IND_LOAD: begin
            s_d.src = indirect;
            s_d.dst = direct;
         end
         default: begin
            s_d.src = direct;
         end
      endcase

      // Read data for the CPU.
      s_d.rdata = rview[3:0];
      s_d.rhit  = rview[4];
   end

   // ****************************************************************
   // Registers
   // ****************************************************************

   // Synchronous reset; the window has no defined reset value in the part, but a
   // known one costs nothing here and keeps simulation clean.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q        <= '0;
         s_q.page   <= DMAM_PAGE_RST[0];
         s_q.ptr_en <= DMAM_NIB_RST[DMAM_PTR_EN_BIT];
         s_q.mid    <= DMAM_NIB_RST[2:0];
         s_q.low    <= DMAM_NIB_RST;
         s_q.status <= DMAM_NIB_RST;
         s_q.window <= DMAM_WINDOW_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Every output comes straight from the state register.
   always_comb begin
      sreg_rdata_o = s_q.rdata;
      sreg_rhit_o  = s_q.rhit;
      addr_vld_o   = s_q.avld;
      opnd_addr_o  = s_q.opnd;
      ind_vld_o    = s_q.ivld;
      src_addr_o   = s_q.src;
      dst_addr_o   = s_q.dst;
      file_req_o   = s_q.file;
      window_o     = s_q.window;
      status_o     = s_q.status;
      ofs_en_o     = s_q.status[DMAM_OFS_EN_BIT];
      ptr_en_o     = s_q.ptr_en;
   end

endmodule : dmam_top

/* File: core/dmam_pkg.sv */
// Package: constants, operation codes and carrier types of the data memory address modifier.
package dmam_pkg;

   // ****************************************************************
   // System register locations (identical in every bank)
   // ****************************************************************
   localparam logic [6:0] DMAM_WINDOW_ADDR    = 7'h78;
   localparam logic [6:0] DMAM_PAGE_ADDR      = 7'h79;
   localparam logic [6:0] DMAM_OFS_HIGH_ADDR  = 7'h7a;
   localparam logic [6:0] DMAM_OFS_MID_ADDR   = 7'h7b;
   localparam logic [6:0] DMAM_OFS_LOW_ADDR   = 7'h7c;
   localparam logic [6:0] DMAM_STATUS_ADDR    = 7'h7f;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int         DMAM_OFS_EN_BIT     = 0;
   localparam int         DMAM_PTR_EN_BIT     = 3;
   localparam logic [3:0] DMAM_PAGE_RST       = 4'h0;
   localparam logic [3:0] DMAM_NIB_RST        = 4'h0;
   localparam logic [3:0] DMAM_WINDOW_RST     = 4'h0;
   localparam logic [3:0] DMAM_ZERO_NIB       = 4'h0;

   // ****************************************************************
   // Operations presented by the instruction decoder
   // ****************************************************************
   typedef enum logic [3:0] {
      DMAM_OP_NONE,
      DMAM_OP_ARITH,
      DMAM_OP_LOGIC,
      DMAM_OP_SKIP_BITS,
      DMAM_OP_SKIP_CMP,
      DMAM_OP_LOAD,
      DMAM_OP_STORE,
      DMAM_OP_MOVE_IMM,
      DMAM_OP_IND_STORE,
      DMAM_OP_IND_LOAD,
      DMAM_OP_FILE_STORE,
      DMAM_OP_FILE_FETCH,
      DMAM_OP_OTHER
   } dmam_op_t;

   // Real data memory address: bank, row and column.
   typedef struct packed {
      logic [3:0] bank;
      logic [2:0] row;
      logic [3:0] col;
   } dmam_addr_t;

   // System register write request from the CPU.
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [3:0] wdata;
   } dmam_sreg_req_t;

   // Register file store request towards the register file.
   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [3:0] wdata;
   } dmam_file_req_t;

   // Whole state of the top module.
   typedef struct packed {
      logic           page;
      logic           ptr_en;
      logic [2:0]     mid;
      logic [3:0]     low;
      logic [3:0]     status;
      logic [3:0]     window;
      logic [3:0]     rdata;
      logic           rhit;
      logic           avld;
      logic           ivld;
      dmam_addr_t     opnd;
      dmam_addr_t     src;
      dmam_addr_t     dst;
      dmam_file_req_t file;
   } dmam_state_t;

endpackage : dmam_pkg

/* File: bench/dmam_checker_assertions.sv */
// Checker: concurrent properties on the ports of the data memory address modifier.
`timescale 1ns/10ps
module dmam_checker
   import dmam_pkg::*;
(
   // Clock, reset and instruction inputs
   input wire logic           sys_clk_i,
   input wire logic           rst_i,
   input wire logic           int_saved_i,
   input wire dmam_op_t       op_i,
   input wire logic [2:0]     opnd_row_i,
   input wire logic [3:0]     opnd_col_i,
   input wire logic [3:0]     greg_data_i,
   input wire logic [6:0]     file_loc_i,
   input wire logic [3:0]     file_rdata_i,
   // Outputs watched
   input wire logic           addr_vld_o,
   input wire dmam_addr_t     opnd_addr_o,
   input wire dmam_addr_t     dst_addr_o,
   input wire dmam_file_req_t file_req_o,
   input wire logic [3:0]     window_o,
   input wire logic [3:0]     status_o,
   input wire logic           ofs_en_o,
   input wire logic           ptr_en_o
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic mod_op;
   // Operations whose address the block may modify, kept as one flag for reuse.
   assign mod_op = op_i inside {[DMAM_OP_ARITH:DMAM_OP_IND_LOAD]};
   a_valid_on_listed: assert property (mod_op |=> addr_vld_o)
      else $error("address valid missing after a listed operation");
   a_valid_off_other: assert property (!mod_op |=> !addr_vld_o)
      else $error("address valid raised for an unlisted operation");
   a_plain_operand: assert property (mod_op && !ofs_en_o |=>
      opnd_addr_o.row == $past(opnd_row_i) && opnd_addr_o.col == $past(opnd_col_i))
      else $error("operand changed with index disabled");
   a_bank_upper_zero: assert property (opnd_addr_o.bank[3:1] == 3'h0)
      else $error("upper bank bits set");
   a_ptr_bank_zero: assert property (op_i == DMAM_OP_IND_STORE && ptr_en_o |=>
      dst_addr_o.bank == 4'h0 && dst_addr_o.col == $past(greg_data_i))
      else $error("pointer transfer bank or column wrong");
   a_file_store_copy: assert property (op_i == DMAM_OP_FILE_STORE |=>
      file_req_o.we && file_req_o.addr == $past(file_loc_i) &&
      file_req_o.wdata == $past(window_o))
      else $error("file store request wrong");
   a_file_fetch_copy: assert property (op_i == DMAM_OP_FILE_FETCH |=>
      window_o == $past(file_rdata_i)) else $error("file fetch did not load window");
   a_int_bank_clear: assert property (int_saved_i ##2 op_i == DMAM_OP_LOAD |=>
      opnd_addr_o.bank == 4'h0) else $error("bank not cleared after interrupt entry");
   a_enable_in_status: assert property (ofs_en_o == status_o[0])
      else $error("index enable differs from status bit zero");
   a_reset_values: assert property ($fell(rst_i) |->
      status_o == 4'h0 && !ptr_en_o && !addr_vld_o) else $error("reset state wrong");
   c_pointer_xfer: cover property (op_i == DMAM_OP_IND_LOAD && ptr_en_o);
   c_index_mod: cover property (mod_op && ofs_en_o);
   c_fetch: cover property (op_i == DMAM_OP_FILE_FETCH);
endmodule : dmam_checker

/* File: bench/dmam_file_model.sv */
// Register file model that takes the block's store requests and answers fetches.
`timescale 1ns/10ps
module dmam_file_model (
   // Clock and store request
   input  wire logic                     sys_clk_i,
   input  wire dmam_pkg::dmam_file_req_t file_req_i,
   // Fetch location and data
   input  wire logic [6:0]               file_loc_i,
   output logic [3:0]                    file_rdata_o
);
   import dmam_pkg::*;
   logic [3:0] mem_q [128];
   // Unwritten cells hold a location pattern, so a stale read looks like zero only where the location's low nibble is AH.
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem_q[i] = 4'(i) ^ 4'ha;
      end
   end
   // Stores land on the first edge after the one where the block raises its strobe.
   always @(posedge sys_clk_i) begin
      if (file_req_i.we) begin
         mem_q[file_req_i.addr] <= file_req_i.wdata;
      end
   end
   assign file_rdata_o = mem_q[file_loc_i];
endmodule : dmam_file_model

/* File: bench/dmam_top_bench.sv */
// Testbench: register, addressing and file transfer scenarios for the address modifier.
`timescale 1ns/10ps
module dmam_top_bench;
   import dmam_pkg::*;
   logic sys_clk_i, rst_i, int_saved, sreg_rhit, addr_vld, ind_vld, ofs_en, ptr_en;
   logic [6:0] sreg_raddr, file_loc;
   logic [3:0] sreg_rdata, greg, file_rdata, window, status, col;
   logic [2:0] row;
   dmam_sreg_req_t sreg_req;
   dmam_op_t op;
   dmam_addr_t opnd_a, src_a, dst_a;
   dmam_file_req_t file_req;
   int error_cnt = 0;
   int comparisons = 0;
   dmam_top dmam_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sreg_req_i(sreg_req),
      .sreg_raddr_i(sreg_raddr), .sreg_rdata_o(sreg_rdata), .sreg_rhit_o(sreg_rhit),
      .int_saved_i(int_saved), .op_i(op), .opnd_row_i(row), .opnd_col_i(col),
      .greg_data_i(greg), .file_loc_i(file_loc), .file_rdata_i(file_rdata),
      .addr_vld_o(addr_vld), .opnd_addr_o(opnd_a), .ind_vld_o(ind_vld), .src_addr_o(src_a),
      .dst_addr_o(dst_a), .file_req_o(file_req), .window_o(window), .status_o(status),
      .ofs_en_o(ofs_en), .ptr_en_o(ptr_en));
   dmam_file_model dmam_file_model_inst (.sys_clk_i(sys_clk_i), .file_req_i(file_req),
      .file_loc_i(file_loc), .file_rdata_o(file_rdata));
   // ****************************************************************
   // Drivers and comparisons
   // ****************************************************************
   task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_nib
   task automatic chk_addr(input dmam_addr_t got, input dmam_addr_t exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_addr
   // Every driver starts on a falling edge, so no signal is driven twice per step.
   task automatic sreg_wr(input logic [6:0] a, input logic [3:0] d);
      @(negedge sys_clk_i) sreg_req = {1'b1, a, d};
      @(negedge sys_clk_i) sreg_req.wr = 1'b0;
   endtask : sreg_wr
   task automatic sreg_rd(input logic [6:0] a, input logic [3:0] exp);
      @(negedge sys_clk_i) sreg_raddr = a;
      @(negedge sys_clk_i) chk_nib(sreg_rdata, exp);
   endtask : sreg_rd
   task automatic set_regs(input logic [3:0] pg, hi, mid, lo, st);
      sreg_wr(7'h79, pg);
      sreg_wr(7'h7a, hi);
      sreg_wr(7'h7b, mid);
      sreg_wr(7'h7c, lo);
      sreg_wr(7'h7f, st);
   endtask : set_regs
   task automatic run_op(input dmam_op_t o, input logic [2:0] r, input logic [3:0] c, g);
      @(negedge sys_clk_i) op = o;
      row = r;
      col = c;
      greg = g;
      @(negedge sys_clk_i) op = DMAM_OP_NONE;
   endtask : run_op
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_regs;
      chk_nib({window[3:2], ofs_en, ptr_en}, 4'h0);
      sreg_rd(7'h70, 4'h0);
      chk_nib({3'h0, sreg_rhit}, 4'h0);
      sreg_rd(7'h7a, 4'h0);
      set_regs(4'hf, 4'hf, 4'hf, 4'hf, 4'hf);
      sreg_rd(7'h79, 4'h1);
      sreg_rd(7'h7a, 4'h8);
      sreg_rd(7'h7b, 4'h7);
      sreg_rd(7'h7c, 4'hf);
      chk_nib({2'h0, ofs_en, ptr_en}, 4'h3);
      set_regs(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
   endtask : test_regs
   task automatic test_bank;
      sreg_wr(7'h79, 4'h1);
      run_op(DMAM_OP_LOAD, 3'h3, 4'h4, 4'h0);
      chk_addr(opnd_a, {4'h1, 3'h3, 4'h4});
      sreg_wr(7'h78, 4'h5);
      chk_nib(window, 4'h5);
      @(negedge sys_clk_i) int_saved = 1'b1;
      @(negedge sys_clk_i) int_saved = 1'b0;
      run_op(DMAM_OP_LOAD, 3'h3, 4'h4, 4'h0);
      chk_addr(opnd_a, {4'h0, 3'h3, 4'h4});
   endtask : test_bank
   task automatic test_plain;
      for (int i = 0; i < 13; i++) begin
         run_op(dmam_op_t'(i), 3'h3, 4'h4, 4'h8);
         chk_nib({3'h0, addr_vld}, {3'h0, i >= 1 && i <= 9});
         chk_nib({3'h0, ind_vld}, {3'h0, i == 8 || i == 9});
      end
      run_op(DMAM_OP_IND_STORE, 3'h3, 4'h4, 4'h8);
      chk_addr(dst_a, {4'h0, 3'h3, 4'h8});
      run_op(DMAM_OP_IND_LOAD, 3'h3, 4'h4, 4'he);
      chk_addr(src_a, {4'h0, 3'h3, 4'he});
      chk_addr(dst_a, {4'h0, 3'h3, 4'h4});
   endtask : test_plain
   task automatic test_index;
      set_regs(4'h1, 4'h7, 4'h1, 4'h2, 4'h1);
      run_op(DMAM_OP_ARITH, 3'h6, 4'h1, 4'h0);
      chk_addr(opnd_a, {4'h1, 3'h7, 4'h3});
      set_regs(4'h0, 4'h0, 4'h0, 4'h1, 4'h1);
      run_op(DMAM_OP_IND_STORE, 3'h3, 4'h4, 4'h8);
      chk_addr(src_a, {4'h0, 3'h3, 4'h5});
      chk_addr(dst_a, {4'h0, 3'h3, 4'h8});
   endtask : test_index
   task automatic test_pointer;
      set_regs(4'h1, 4'h8, 4'h6, 4'h0, 4'h0);
      run_op(DMAM_OP_IND_STORE, 3'h3, 4'h4, 4'h8);
      chk_addr(dst_a, {4'h0, 3'h6, 4'h8});
      run_op(DMAM_OP_IND_LOAD, 3'h3, 4'h4, 4'he);
      chk_addr(src_a, {4'h0, 3'h6, 4'he});
      run_op(DMAM_OP_LOAD, 3'h3, 4'h4, 4'h0);
      chk_addr(opnd_a, {4'h1, 3'h3, 4'h4});
      set_regs(4'h1, 4'h8, 4'h6, 4'h1, 4'h1);
      run_op(DMAM_OP_IND_STORE, 3'h1, 4'h4, 4'h8);
      chk_addr(src_a, {4'h1, 3'h7, 4'h5});
      chk_addr(dst_a, {4'h0, 3'h6, 4'h8});
   endtask : test_pointer
   task automatic test_file;
      sreg_wr(7'h78, 4'h9);
      @(negedge sys_clk_i) file_loc = 7'h15;
      run_op(DMAM_OP_FILE_STORE, 3'h0, 4'h0, 4'h0);
      chk_nib({file_req.we, file_req.addr[6:4]}, 4'h9);
      chk_nib(file_req.wdata, 4'h9);
      sreg_wr(7'h78, 4'h0);
      run_op(DMAM_OP_FILE_FETCH, 3'h0, 4'h0, 4'h0);
      chk_nib(window, 4'h9);
   endtask : test_file
   task automatic stop_test;
      $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   // Clock at 20 MHz.
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // Bounded run: a hang counts as a mismatch.
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      error_cnt++;
      stop_test();
   end
   // Main sequence, reset held for four cycles.
   initial begin
      {rst_i, int_saved, sreg_req, sreg_raddr, row, col, greg} = {2'b10, 30'h0};
      op = DMAM_OP_NONE;
      file_loc = 7'h0;
      repeat (4) @(negedge sys_clk_i);
      rst_i = 1'b0;
      test_regs();
      test_bank();
      test_plain();
      test_index();
      test_pointer();
      test_file();
      stop_test();
   end
endmodule : dmam_top_bench
bind dmam_top dmam_checker dmam_checker_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .int_saved_i(int_saved_i), .op_i(op_i), .opnd_row_i(opnd_row_i), .opnd_col_i(opnd_col_i),
   .greg_data_i(greg_data_i), .file_loc_i(file_loc_i), .file_rdata_i(file_rdata_i),
   .addr_vld_o(addr_vld_o), .opnd_addr_o(opnd_addr_o), .dst_addr_o(dst_addr_o),
   .file_req_o(file_req_o), .window_o(window_o), .status_o(status_o),
   .ofs_en_o(ofs_en_o), .ptr_en_o(ptr_en_o));
